// [segment_table_walker_defines.vh]
// Constants for the segment table walker
`ifndef SEGMENT_TABLE_WALKER_DEFINES_VH
`define SEGMENT_TABLE_WALKER_DEFINES_VH

`define STW_EFFECTIVE_SEGMENT_ID_W          36
`define STW_BASE_W          52
`define STW_HASH_W          5
`define STW_GROUP_ENTRIES   8
`define STW_MAX_FETCHES     16
`define STW_SLOT_W          3
`define STW_ENTRY_BYTES_W   4
`define STW_FETCH_ATTR      4'b0010
`define STW_DS_ATTR         4'b0101
`define STW_DW0_VALID_BIT   7
`define STW_DW0_TSEL_BIT    6
`define STW_DW0_SKEY_BIT    5
`define STW_DW0_UKEY_BIT    4
`define STW_BRIDGE_ENTRIES  16
`define STW_SLB_IDX_W       5
`define STW_MAX_OUTSTANDING 4

`endif

// [segment_entry_matcher.v]
// Compares one fetched segment table entry against the access
`timescale 1ns/1ps
`default_nettype none
`include "segment_table_walker_defines.vh"

module segment_entry_matcher
(
    input  wire [63:0]              entry_dw0_i,
    input  wire [`STW_EFFECTIVE_SEGMENT_ID_W-1:0]   effective_segment_id_i,
    output wire                     hit_o
);
    wire effective_segment_id_eq;
    wire entry_valid;

    // Entry bits 0-35 sit in dw0[63:28]
    assign effective_segment_id_eq     = (entry_dw0_i[63:64-`STW_EFFECTIVE_SEGMENT_ID_W] == effective_segment_id_i);
    assign entry_valid = entry_dw0_i[`STW_DW0_VALID_BIT];
    assign hit_o       = effective_segment_id_eq & entry_valid;
endmodule
`default_nettype wire

// [segment_group_addr.v]
// Builds primary and secondary entry-group physical addresses
`timescale 1ns/1ps
`default_nettype none
`include "segment_table_walker_defines.vh"

module segment_group_addr
(
    input  wire [`STW_BASE_W-1:0]   table_base_i,
    input  wire [`STW_EFFECTIVE_SEGMENT_ID_W-1:0]   effective_segment_id_i,
    output wire [63:0]              primary_addr_o,
    output wire [63:0]              secondary_addr_o
);
    wire [`STW_HASH_W-1:0] hash1;
    wire [`STW_HASH_W-1:0] hash2;

    assign hash1 = effective_segment_id_i[`STW_HASH_W-1:0];
    assign hash2 = ~hash1;
    assign primary_addr_o   = {table_base_i, hash1, 7'b000_0000};
    assign secondary_addr_o = {table_base_i, hash2, 7'b000_0000};
endmodule
`default_nettype wire

// [segment_table_walker.v]
// Segment table search engine with lookaside fill and direct-store routing
//
`timescale 1ns/1ps
`default_nettype none
`include "segment_table_walker_defines.vh"

module segment_table_walker
#(
    parameter DIRECT_STORE_EN = 1,
    parameter MAX_OUTSTANDING = `STW_MAX_OUTSTANDING
)
(
    input  wire                     clk_i,
    input  wire                     rst_b_i,
    // Access side
    input  wire                     miss_req_i,
    input  wire [63:0]              eff_addr_i,
    input  wire                     is_fetch_i,
    input  wire                     xlate_en_i,
    input  wire                     bta_hit_i,
    input  wire                     bridge_mode_i,
    input  wire [`STW_BASE_W-1:0]   table_base_i,
    output reg                      access_stall_o,
    output reg                      search_done_o,
    output reg                      instruction_storage_fault_o,
    output reg                      data_storage_fault_o,
    // Memory read port
    output reg                      mem_req_o,
    output reg  [63:0]              mem_addr_o,
    output reg  [3:0]               storage_attribute_bits_o,
    input  wire                     mem_ack_i,
    input  wire                     mem_rvalid_i,
    input  wire [63:0]              mem_rdata_dw0_i,
    input  wire [63:0]              mem_rdata_dw1_i,
    // Lookaside buffer fill
    output reg                      slb_wr_o,
    output reg  [`STW_SLB_IDX_W-1:0] slb_idx_o,
    output reg  [63:0]              slb_dw0_o,
    output reg  [63:0]              slb_dw1_o,
    // Direct-store routing
    output reg                      direct_store_o,
    output reg  [3:0]               ds_attribute_bits_o,
    output reg                      ds_key_o,
    input  wire                     user_mode_i,
    // Invalidate and sync
    input  wire                     inval_req_i,
    input  wire                     inval_done_i,
    input  wire                     sync_req_i,
    output reg                      sync_stall_o
);
    localparam S_IDLE  = 6'b00_0001;
    localparam S_ADDR  = 6'b00_0010;
    localparam S_FETCH = 6'b00_0100;
    localparam S_FILL  = 6'b00_1000;
    localparam S_DONE  = 6'b01_0000;
    localparam S_FAULT = 6'b10_0000;

    reg        rst_sync1_r;
    reg        rst_sync2_r;
    wire       rst_b;

    reg  [5:0]              state_r;
    reg  [5:0]              state_nxt;
    reg  [63:0]             prim_addr_r;
    reg  [63:0]             sec_addr_r;
    reg  [`STW_EFFECTIVE_SEGMENT_ID_W-1:0]  effective_segment_id_r;
    reg                     is_fetch_r;
    reg  [4:0]              issued_r;
    reg  [4:0]              returned_r;
    reg  [2:0]              outstanding_r;
    reg                     hit_r;
    reg  [63:0]             hit_dw0_r;
    reg  [63:0]             hit_dw1_r;
    reg                     inval_pending_r;
    reg  [`STW_SLB_IDX_W-1:0] fill_ptr_r;

    wire [63:0] prim_addr;
    wire [63:0] sec_addr;
    wire        entry_hit;
    wire        can_issue;
    wire        all_issued;
    wire        all_back;
    wire        ret_ok;
    wire        issue_go;
    wire        ret_hit;
    wire        inval_busy;

    // Effective segment ID is the top 36 address bits
    function [`STW_EFFECTIVE_SEGMENT_ID_W-1:0] effective_segment_id_of;
        input [63:0] addr;
        begin
            effective_segment_id_of = addr[63:64-`STW_EFFECTIVE_SEGMENT_ID_W];
        end
    endfunction

    // Protection key sent along with a direct-store access
    function key_select;
        input        user;
        input [63:0] dw0;
        begin
            key_select = user ? dw0[`STW_DW0_UKEY_BIT] : dw0[`STW_DW0_SKEY_BIT];
        end
    endfunction

    // Bridge mode pins a slot per segment; otherwise rotate through the upper half
    function [`STW_SLB_IDX_W-1:0] slb_fill_idx;
        input                      bridge;
        input [`STW_EFFECTIVE_SEGMENT_ID_W-1:0]    effective_segment_id;
        input [`STW_SLB_IDX_W-1:0] ptr;
        begin
            if (bridge)
                slb_fill_idx = {1'b0, effective_segment_id[3:0]};
            else
                slb_fill_idx = 5'd`STW_BRIDGE_ENTRIES | {1'b0, ptr[3:0]};
        end
    endfunction

    // Entry address: group base plus slot times 16 bytes
    function [63:0] entry_addr;
        input [63:0] group_base;
        input [`STW_SLOT_W-1:0] slot;
        begin
            entry_addr = group_base | {57'd0, slot, 4'b0000};
        end
    endfunction

    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_sync1_r <= 1'b0;
            rst_sync2_r <= 1'b0;
        end
        else
        begin
            rst_sync1_r <= 1'b1;
            rst_sync2_r <= rst_sync1_r;
        end
    end
    assign rst_b = rst_sync2_r;

    segment_group_addr u_group_addr
    (
        .table_base_i     (table_base_i),
        .effective_segment_id_i           (effective_segment_id_of(eff_addr_i)),
        .primary_addr_o   (prim_addr),
        .secondary_addr_o (sec_addr)
    );

    segment_entry_matcher u_matcher
    (
        .entry_dw0_i (mem_rdata_dw0_i),
        .effective_segment_id_i      (effective_segment_id_r),
        .hit_o       (entry_hit)
    );

    assign all_issued = (issued_r == 5'd`STW_MAX_FETCHES);
    assign all_back   = (returned_r == 5'd`STW_MAX_FETCHES);
    assign ret_ok     = (state_r == S_FETCH) && mem_rvalid_i;
    assign can_issue  = !all_issued && !hit_r &&
                        ({29'd0, outstanding_r} < MAX_OUTSTANDING);
    assign ret_hit    = ret_ok && entry_hit;
    // Next request may leave in the cycle that the current one is accepted
    assign issue_go   = can_issue && !(mem_req_o && !mem_ack_i);

    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE:
                if (miss_req_i)
                    state_nxt = S_ADDR;
            S_ADDR:
                state_nxt = S_FETCH;
            S_FETCH:
                // Outstanding reads drain before the fill
                if ((hit_r || ret_hit) && outstanding_r == 3'd0 && !mem_req_o)
                    state_nxt = S_FILL;
                else if (all_back && !hit_r)
                    state_nxt = S_FAULT;
            S_FILL:
                state_nxt = S_DONE;
            S_DONE:
                state_nxt = S_IDLE;
            S_FAULT:
                state_nxt = S_IDLE;
            default:
                state_nxt = S_IDLE;
        endcase
    end

    always @(posedge clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r                     <= S_IDLE;
            prim_addr_r                 <= 64'h0000_0000_0000_0000;
            sec_addr_r                  <= 64'h0000_0000_0000_0000;
            effective_segment_id_r                      <= {`STW_EFFECTIVE_SEGMENT_ID_W{1'b0}};
            is_fetch_r                  <= 1'b0;
            issued_r                    <= 5'd0;
            returned_r                  <= 5'd0;
            outstanding_r               <= 3'd0;
            hit_r                       <= 1'b0;
            hit_dw0_r                   <= 64'h0000_0000_0000_0000;
            hit_dw1_r                   <= 64'h0000_0000_0000_0000;
            access_stall_o              <= 1'b0;
            search_done_o               <= 1'b0;
            instruction_storage_fault_o <= 1'b0;
            data_storage_fault_o        <= 1'b0;
            mem_req_o                   <= 1'b0;
            mem_addr_o                  <= 64'h0000_0000_0000_0000;
            storage_attribute_bits_o    <= `STW_FETCH_ATTR;
            slb_wr_o                    <= 1'b0;
            slb_idx_o                   <= {`STW_SLB_IDX_W{1'b0}};
            slb_dw0_o                   <= 64'h0000_0000_0000_0000;
            slb_dw1_o                   <= 64'h0000_0000_0000_0000;
            fill_ptr_r                  <= {`STW_SLB_IDX_W{1'b0}};
            direct_store_o              <= 1'b0;
            ds_attribute_bits_o         <= `STW_DS_ATTR;
            ds_key_o                    <= 1'b0;
        end
        else
        begin
            state_r                     <= state_nxt;
            search_done_o               <= 1'b0;
            instruction_storage_fault_o <= 1'b0;
            data_storage_fault_o        <= 1'b0;
            slb_wr_o                    <= 1'b0;
            direct_store_o              <= 1'b0;
            storage_attribute_bits_o    <= `STW_FETCH_ATTR;
            case (state_r)
                S_IDLE:
                    if (miss_req_i)
                    begin
                        access_stall_o <= 1'b1;
                        prim_addr_r    <= prim_addr;
                        sec_addr_r     <= sec_addr;
                        effective_segment_id_r         <= effective_segment_id_of(eff_addr_i);
                        is_fetch_r     <= is_fetch_i;
                        issued_r       <= 5'd0;
                        returned_r     <= 5'd0;
                        outstanding_r  <= 3'd0;
                        hit_r          <= 1'b0;
                    end
                S_FETCH:
                begin
                    // Primary group entries first, then secondary
                    if (mem_req_o && mem_ack_i)
                        mem_req_o <= 1'b0;
                    if (issue_go)
                    begin
                        mem_req_o  <= 1'b1;
                        mem_addr_o <= entry_addr(issued_r[3] ? sec_addr_r : prim_addr_r,
                                                 issued_r[2:0]);
                        issued_r   <= issued_r + 5'd1;
                    end
                    outstanding_r <= outstanding_r
                                     + {2'b00, issue_go}
                                     - {2'b00, ret_ok};
                    if (ret_ok)
                    begin
                        returned_r <= returned_r + 5'd1;
                        if (entry_hit && !hit_r)
                        begin
                            hit_r     <= 1'b1;
                            hit_dw0_r <= mem_rdata_dw0_i;
                            hit_dw1_r <= mem_rdata_dw1_i;
                        end
                    end
                end
                S_FILL:
                begin
                    slb_wr_o  <= 1'b1;
                    slb_dw0_o <= hit_dw0_r;
                    slb_dw1_o <= hit_dw1_r;
                    // Lookaside write leads the completion pulse by one cycle
                    slb_idx_o <= slb_fill_idx(bridge_mode_i, effective_segment_id_r, fill_ptr_r);
                    if (!bridge_mode_i)
                        fill_ptr_r <= fill_ptr_r + 1'b1;
                    if (DIRECT_STORE_EN != 0 && xlate_en_i && !bta_hit_i &&
                        hit_dw0_r[`STW_DW0_TSEL_BIT])
                    begin
                        direct_store_o      <= 1'b1;
                        ds_attribute_bits_o <= `STW_DS_ATTR;
                        ds_key_o            <= key_select(user_mode_i, hit_dw0_r);
                    end
                end
                S_DONE:
                begin
                    search_done_o  <= 1'b1;
                    access_stall_o <= 1'b0;
                end
                S_FAULT:
                begin
                    instruction_storage_fault_o <= is_fetch_r;
                    data_storage_fault_o        <= !is_fetch_r;
                    access_stall_o              <= 1'b0;
                end
                default:
                    mem_req_o <= 1'b0;
            endcase
        end
    end

    // Sync holds until own invalidate completes; new request wins over done
    assign inval_busy = inval_req_i || (inval_pending_r && !inval_done_i);
    always @(posedge clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            inval_pending_r <= 1'b0;
            sync_stall_o    <= 1'b0;
        end
        else
        begin
            if (inval_req_i)
                inval_pending_r <= 1'b1;
            else if (inval_done_i)
                inval_pending_r <= 1'b0;
            sync_stall_o <= sync_req_i && inval_busy;
        end
    end
endmodule
`default_nettype wire

// [segment_table_walker_checker.sv]
// Port-level assertions for the segment table walker
`timescale 1ns/1ps
`default_nettype none
module stw_checker
(
    input wire logic        clk_i,
    input wire logic        rst_b_i,
    input wire logic        miss_req_i,
    input wire logic [63:0] eff_addr_i,
    input wire logic        is_fetch_i,
    input wire logic        bridge_mode_i,
    input wire logic        inval_req_i,
    input wire logic        sync_req_i,
    input wire logic        mem_ack_i,
    input wire logic        access_stall_o,
    input wire logic        search_done_o,
    input wire logic        instruction_storage_fault_o,
    input wire logic        data_storage_fault_o,
    input wire logic        mem_req_o,
    input wire logic [63:0] mem_addr_o,
    input wire logic [3:0]  storage_attribute_bits_o,
    input wire logic        slb_wr_o,
    input wire logic [4:0]  slb_idx_o,
    input wire logic [63:0] slb_dw0_o,
    input wire logic        direct_store_o,
    input wire logic        sync_stall_o
);
    logic        busy_r;
    logic        fetch_r;
    logic [35:0] effective_segment_id_r;
    logic [4:0]  cnt_r;
    logic [1:0]  up_r;
    wire logic   flt_w = instruction_storage_fault_o | data_storage_fault_o;
    // Shadow of the search in flight
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            busy_r <= 1'b0;
            fetch_r <= 1'b0;
            effective_segment_id_r <= 36'h0_0000_0000;
            cnt_r <= 5'h00;
            up_r <= 2'h0;
        end
        else
        begin
            if (up_r != 2'h3)
                up_r <= up_r + 2'h1;
            if (!busy_r && miss_req_i && up_r == 2'h3)
            begin
                busy_r <= 1'b1;
                fetch_r <= is_fetch_i;
                effective_segment_id_r <= eff_addr_i[63:28];
                cnt_r <= 5'h00;
            end
            else
            begin
                if (search_done_o || flt_w)
                    busy_r <= 1'b0;
                if (mem_req_o && mem_ack_i)
                    cnt_r <= cnt_r + 5'h01;
            end
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    attr_fixed_a: assert property (storage_attribute_bits_o == 4'b0010)
        else $error("fetch attributes wrong");
    req_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
        else $error("request dropped early");
    req_search_a: assert property (mem_req_o |-> access_stall_o && busy_r)
        else $error("fetch outside search");
    fault_count_a: assert property (flt_w |-> cnt_r == 5'h10 && !search_done_o)
        else $error("fault before sixteen fetches");
    fault_kind_a: assert property (flt_w |-> instruction_storage_fault_o == fetch_r)
        else $error("wrong fault kind");
    fill_match_a: assert property (slb_wr_o |-> slb_dw0_o[7] && slb_dw0_o[63:28] == effective_segment_id_r)
        else $error("filled entry not a hit");
    fill_done_a: assert property (slb_wr_o |=> search_done_o)
        else $error("no completion after fill");
    ds_route_a: assert property (direct_store_o |-> slb_wr_o && slb_dw0_o[6])
        else $error("direct store without select bit");
    bridge_idx_a: assert property (slb_wr_o && bridge_mode_i |-> slb_idx_o == {1'b0, effective_segment_id_r[3:0]})
        else $error("bridge index wrong");
    sync_hold_a: assert property (up_r == 2'h3 && sync_req_i && inval_req_i |=> sync_stall_o)
        else $error("sync not stalled");
    cover property (search_done_o);
    cover property (instruction_storage_fault_o);
    cover property (direct_store_o);
endmodule
bind segment_table_walker stw_checker u_chk (.*);
`default_nettype wire

// [stw_mem_model.sv]
// Memory holding one pair of segment entry groups
`timescale 1ns/1ps
`default_nettype none
module stw_mem_model
(
    input  wire logic        clk_i,
    input  wire logic        req_i,
    input  wire logic [63:0] addr_i,
    output var  logic        ack_o,
    output var  logic        rvalid_o,
    output var  logic [63:0] dw0_o,
    output var  logic [63:0] dw1_o
);
    logic [63:0] dw0 [16];
    logic [63:0] dw1 [16];
    logic [3:0]  q [$];
    int          lat = 0;
    int          gap = 0;
    initial
    begin
        ack_o = 1'b0;
        rvalid_o = 1'b0;
        dw0_o = 64'h0000_0000_0000_0000;
        dw1_o = 64'h0000_0000_0000_0000;
    end
    // Accepts and returns after lat idle cycles; idle data lines keep toggling
    always @(posedge clk_i)
    begin
        ack_o <= req_i && !ack_o && gap >= lat;
        rvalid_o <= 1'b0;
        dw0_o <= ~dw0_o;
        dw1_o <= ~dw1_o;
        gap <= gap + 1;
        if (req_i && ack_o)
            q.push_back({addr_i[7], addr_i[6:4]});
        if (q.size() > 0 && gap >= lat)
        begin
            rvalid_o <= 1'b1;
            dw0_o <= dw0[q[0]];
            dw1_o <= dw1[q[0]];
            void'(q.pop_front());
            gap <= 0;
        end
    end
endmodule
`default_nettype wire

// [segment_table_walker_tb_top.sv]
// Self-checking bench for the segment table walker
`timescale 1ns/1ps
`default_nettype none
`include "segment_table_walker_defines.vh"
module segment_table_walker_tb_top;
    localparam logic [63:0] EA0 = 64'h1234_5678_9000_0000;
    localparam logic [63:0] EA1 = 64'hFEDC_BA98_7000_0000;
    logic clk_i = 1'b0, rst_b_i = 1'b0, miss_req_i = 1'b0, is_fetch_i = 1'b0;
    logic xlate_en_i = 1'b1, bta_hit_i = 1'b0, bridge_mode_i = 1'b0, user_mode_i = 1'b0;
    logic inval_req_i = 1'b0, inval_done_i = 1'b0, sync_req_i = 1'b0;
    logic [63:0] eff_addr_i = EA0;
    logic [`STW_BASE_W-1:0] table_base_i = 52'h0_0005_C804_2A17;
    logic access_stall_o, search_done_o, instruction_storage_fault_o, data_storage_fault_o;
    logic mem_req_o, mem_ack_i, mem_rvalid_i, slb_wr_o, direct_store_o, ds_key_o, sync_stall_o;
    logic [3:0]  storage_attribute_bits_o, ds_attribute_bits_o;
    logic [4:0]  slb_idx_o, sv_idx;
    logic [63:0] mem_addr_o, mem_rdata_dw0_i, mem_rdata_dw1_i, slb_dw0_o, slb_dw1_o, sv_dw0, sv_dw1;
    logic        sv_ds, sv_key;
    int          nacc, errors = 0, n_checks = 0;
    segment_table_walker DUT (.*);
    stw_mem_model MEM (.clk_i(clk_i), .req_i(mem_req_o), .addr_i(mem_addr_o), .ack_o(mem_ack_i),
        .rvalid_o(mem_rvalid_i), .dw0_o(mem_rdata_dw0_i), .dw1_o(mem_rdata_dw1_i));
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            errors++;
        end
    endtask
    always @(posedge clk_i)
    begin
        if (slb_wr_o === 1'b1)
            {sv_dw0, sv_dw1, sv_idx, sv_ds, sv_key} = {slb_dw0_o, slb_dw1_o, slb_idx_o,
                direct_store_o, ds_key_o};
        if (mem_req_o === 1'b1 && mem_ack_i === 1'b1)
        begin
            nacc++;
            chk("fetch_addr", 1, mem_addr_o[3:0] == 4'h0 &&
                (mem_addr_o[63:7] == {table_base_i, eff_addr_i[32:28]} ||
                 mem_addr_o[63:7] == {table_base_i, ~eff_addr_i[32:28]}));
        end
    end
    task results;
        if (errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Only the chosen slot is valid; second word written before the first
    task automatic fill(input logic [63:0] ea, input int slot, input logic [3:0] flags);
        for (int i = 0; i < 16; i++)
        begin
            MEM.dw1[{ea[28] ^ i[3], i[2:0]}] = 64'hA5A5_0000_0000_0000 | 64'(i);
            MEM.dw0[{ea[28] ^ i[3], i[2:0]}] = {ea[63:28], 20'h0_0000, i == slot ? flags : 4'h0,
                4'h0};
        end
    endtask
    task automatic run(input logic [63:0] ea, input logic f, output int res);
        @(posedge clk_i);
        {eff_addr_i, is_fetch_i, miss_req_i} <= {ea, f, 1'b1};
        nacc = 0;
        sv_dw0 = 'x;
        @(posedge clk_i);
        miss_req_i <= 1'b0;
        res = 0;
        for (int k = 0; k < 500 && res == 0; k++)
        begin
            @(posedge clk_i);
            #1;
            res = (search_done_o === 1'b1) + 2 * (instruction_storage_fault_o === 1'b1)
                + 4 * (data_storage_fault_o === 1'b1);
            if (k == 0)
                chk("stall_on", 1, access_stall_o);
        end
        chk("stall_off", 0, access_stall_o);
        if (res == 0)
        begin
            $display("ERROR search timed out");
            errors++;
            results();
        end
    endtask
    task automatic t_hit(input int slot, input int lat);
        int r;
        MEM.lat = lat;
        fill(EA0, slot, 4'h8);
        run(EA0, 1'b0, r);
        chk("done", 1, r);
        chk("slb_dw0", MEM.dw0[{EA0[28] ^ slot[3], slot[2:0]}], sv_dw0);
        chk("slb_dw1", 64'hA5A5_0000_0000_0000 | 64'(slot), sv_dw1);
        chk("fetch_max", 1, nacc <= 16);
        chk("slb_idx_top", 1, sv_idx[4]);
        chk("ds_off", 0, sv_ds);
    endtask
    task automatic t_fault;
        int r;
        MEM.lat = 1;
        fill(EA1, 16, 4'h0);
        run(EA1, 1'b1, r);
        chk("isi", 2, r);
        chk("fetches", 16, nacc);
        fill(EA1, 3, 4'h8);
        MEM.dw0[{EA1[28], 3'h3}][63] = 1'b0;
        run(EA1, 1'b0, r);
        chk("dsi", 4, r);
    endtask
    task automatic t_dstore;
        int r;
        logic [2:0] c;
        MEM.lat = 0;
        fill(EA0, 9, 4'hE);
        for (int n = 0; n < 4; n++)
        begin
            c = {n == 3, n == 2, n == 1};
            @(posedge clk_i);
            {xlate_en_i, bta_hit_i, user_mode_i} <= {~c[2], c[1], c[0]};
            run(EA0, 1'b0, r);
            chk("ds_done", 1, r);
            chk("ds_route", c[2:1] == 2'b00, sv_ds);
            if (c[2:1] == 2'b00)
            begin
                chk("ds_key", !c[0], sv_key);
                chk("ds_attr", `STW_DS_ATTR, ds_attribute_bits_o);
            end
        end
        @(posedge clk_i);
        {xlate_en_i, bta_hit_i, user_mode_i} <= 3'b100;
    endtask
    task automatic t_bridge;
        int r;
        fill(64'h0000_0000_A000_0000, 12, 4'h8);
        @(posedge clk_i);
        bridge_mode_i <= 1'b1;
        run(64'h0000_0000_A000_0000, 1'b0, r);
        chk("bridge_idx", 5'h0A, sv_idx);
        @(posedge clk_i);
        bridge_mode_i <= 1'b0;
    endtask
    task automatic t_sync;
        @(posedge clk_i);
        {sync_req_i, inval_req_i} <= 2'b11;
        @(posedge clk_i);
        inval_req_i <= 1'b0;
        @(posedge clk_i);
        #1 chk("sync_stall", 1, sync_stall_o);
        @(posedge clk_i);
        inval_done_i <= 1'b1;
        @(posedge clk_i);
        inval_done_i <= 1'b0;
        @(posedge clk_i);
        #1 chk("sync_free", 0, sync_stall_o);
        @(posedge clk_i);
        sync_req_i <= 1'b0;
    endtask
    initial
        forever #5 clk_i = ~clk_i;
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        t_hit(0, 0);
        t_hit(15, 3);
        t_fault;
        t_dstore;
        t_bridge;
        t_sync;
        results();
    end
endmodule
`default_nettype wire
